// *** design/tdu_pkg.sv ***
/*
  Constants, register map and carrier types of the tamper detection unit.
  Assumes a 32-bit APB slave port and a kernel clock used as mclk.
*/
package tdu_pkg;

  // ********************************************************************
  // Sizes and bus
  // ********************************************************************
  localparam int NIN_MAX = 8;
  localparam int NOUT_MAX = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int ROUTE_FW = 4;

  // ********************************************************************
  // Register offsets (byte addresses)
  // ********************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FILT = 8'h04;
  localparam logic [7:0] OFS_IRQEN = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  localparam logic [7:0] OFS_CLR = 8'h10;
  localparam logic [7:0] OFS_ROUTE = 8'h14;
  localparam logic [7:0] OFS_ASSET = 8'h18;

  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int CTRL_EN_LSB = 0;
  localparam int CTRL_TRG_LSB = 8;
  localparam int CTRL_AM_LSB = 16;
  localparam int CTRL_TS_BIT = 24;
  localparam int CTRL_BLK_BIT = 25;
  localparam int CTRL_SHARE_BIT = 26;
  localparam int CTRL_AFLT_BIT = 27;
  localparam int FILT_FREQ_LSB = 0;
  localparam int FILT_CNT_LSB = 3;
  localparam int FILT_PRCH_LSB = 5;
  localparam int FILT_PUDIS_BIT = 7;
  localparam int IRQ_PER_LSB = 0;
  localparam int IRQ_GLB_BIT = 8;
  localparam int STAT_FLAG_LSB = 0;
  localparam int STAT_TSF_BIT = 8;
  localparam int STAT_TIMESTAMP_OVERFLOW_FLAG_BIT = 9;
  localparam int ASSET_EN_BIT = 0;

  // ********************************************************************
  // Writable masks and reset values
  // ********************************************************************
  localparam logic [31:0] CTRL_WMASK = 32'h0fff_ffff;
  localparam logic [31:0] FILT_WMASK = 32'h0000_00ff;
  localparam logic [31:0] IRQEN_WMASK = 32'h0000_01ff;
  localparam logic [31:0] ASSET_WMASK = 32'h0000_0001;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] FILT_RST = 32'h0000_0000;
  localparam logic [2:0] FREQ_SLOWEST = 3'h0;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int KERNEL_HZ = 32768;
  localparam int SLOW_RATE_HZ = 1;
  localparam int SLOW_RATE_CYC = KERNEL_HZ / SLOW_RATE_HZ;
  localparam int FREQ_STEPS = 7;
  localparam int MIN_GAP_CYC = 16;
  localparam int ACT_PERIOD_DEF = 64;
  localparam int ACT_PERIOD_MIN = 4;
  localparam int ACT_FLT_MIN = 2;
  localparam int ACT_HIST_W = 4;
  localparam int LVL_CNT_W = 4;

  // ********************************************************************
  // Message generator
  // ********************************************************************
  localparam int LFSR_W = 16;
  localparam logic [15:0] LFSR_SEED = 16'hace1;
  localparam logic [15:0] LFSR_TAPS = 16'hb400;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic [1:0] {
    SMP_IDLE,
    SMP_PRECH,
    SMP_HOLD,
    SMP_SAMPLE
  } tdu_smp_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } tdu_apb_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } tdu_apb_rsp_t;

endpackage

// *** design/tdu_top.sv ***
/*
  Tamper detection unit: passive edge/level detection with precharge and
  sampling, active message check, flags, interrupt, timestamp trigger and
  asset blocking, with an APB register port.
  Assumes mclk is the kernel clock and tamper pins are asynchronous inputs
  passed through a local two-stage synchroniser.
*/
// Contract
// - Filter count zero: enabled input detects on its selected single edge.
// - Trigger select resets to rising edge.
// - Edge mode: no periodic sampling and no precharge pulse.
// - Pull-up disable set: internal pull-up never applied.
// - Level mode: detect after 2, 4 or 8 consecutive samples at level.
// - Level mode precharge pulse lasts 1, 2, 4 or 8 kernel cycles.
// - Schmitt trigger off whenever pull-up is not applied; code keeps it on in edge mode, active mode and precharge with pull-up disabled.
// - Three-bit field selects sample rate 1 to 128 Hz at 32768 Hz.
// - Sample rate field resets to the slowest rate.
// - An input detects only while its enable bit is set.
// - Interrupt raised on detection with global or per-input enable.
// - Flag sticky; cleared by writing zero or by clear register.
// - Tamper-to-timestamp set: detection sets timestamp flag, and overflow flag if timestamp flag already set.
// - Tamper timestamp works regardless of ordinary timestamp enable.
// - Protected asset blocked after detection or while block bit set.
// - Active mode: send random message, flag input on mismatch.
// - Active input compares against same-index output by default.
// - Output share set: input compares against its selected output.
// - Active filter: tamper after two of four comparisons mismatch.
`timescale 1ns/1ps
module tdu_top #(
  parameter int NIN = 4,
  parameter int NOUT = 4,
  parameter int SAMPLE_BASE_CYC = tdu_pkg::SLOW_RATE_CYC,
  parameter int ACT_PERIOD_CYC = tdu_pkg::ACT_PERIOD_DEF,
  parameter bit FLAG_CLR_BY_REG = 1'b1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // APB slave
  input wire tdu_pkg::tdu_apb_req_t apb_req,
  output tdu_pkg::tdu_apb_rsp_t apb_rsp,
  // Backup domain write unlock
  input wire logic backup_write_unlock,
  // Tamper pins
  input wire logic [NIN-1:0] tamper_input_pin,
  output logic [NOUT-1:0] tamper_output_pin,
  output logic [NIN-1:0] pullup_en,
  output logic [NIN-1:0] schmitt_en,
  // Actions
  output logic irq,
  output logic ts_capture,
  output logic asset_block
);

  // ********************************************************************
  // Elaboration checks
  // ********************************************************************
  if (NIN < 1 || NIN > tdu_pkg::NIN_MAX)
    $error("NIN out of range");
  if (NOUT < 1 || NOUT > tdu_pkg::NOUT_MAX || NOUT > tdu_pkg::LFSR_W)
    $error("NOUT out of range");
  if (SAMPLE_BASE_CYC < (tdu_pkg::MIN_GAP_CYC << tdu_pkg::FREQ_STEPS))
    $error("SAMPLE_BASE_CYC too small for the fastest rate");
  if (ACT_PERIOD_CYC < tdu_pkg::ACT_PERIOD_MIN)
    $error("ACT_PERIOD_CYC too small");

  localparam int SELW = (NOUT > 1) ? $clog2(NOUT) : 1;

  // ********************************************************************
  // Registers and decoded fields
  // ********************************************************************
  logic [31:0] ctrl_reg;
  logic [31:0] filt_reg;
  logic [31:0] irqen_reg;
  logic [31:0] route_reg;
  logic [31:0] asset_reg;
  logic [NIN-1:0] flag_reg;
  logic [NIN-1:0] flag_next;
  logic tsf_reg;
  logic timestamp_overflow_flag_reg;
  logic [NIN-1:0] in_en;
  logic [NIN-1:0] trg_sel;
  logic [NIN-1:0] act_sel;
  logic [NIN-1:0] per_ie;
  logic [2:0] freq_sel;
  logic [1:0] flt_cnt;
  logic [1:0] prch_sel;
  logic pudis;
  logic edge_mode;
  logic ts_en;

  assign in_en = ctrl_reg[tdu_pkg::CTRL_EN_LSB +: NIN];
  assign trg_sel = ctrl_reg[tdu_pkg::CTRL_TRG_LSB +: NIN];
  assign act_sel = ctrl_reg[tdu_pkg::CTRL_AM_LSB +: NIN];
  assign per_ie = irqen_reg[tdu_pkg::IRQ_PER_LSB +: NIN];
  assign freq_sel = filt_reg[tdu_pkg::FILT_FREQ_LSB +: 3];
  assign flt_cnt = filt_reg[tdu_pkg::FILT_CNT_LSB +: 2];
  assign prch_sel = filt_reg[tdu_pkg::FILT_PRCH_LSB +: 2];
  assign pudis = filt_reg[tdu_pkg::FILT_PUDIS_BIT];
  assign edge_mode = (flt_cnt == 2'h0);
  assign ts_en = ctrl_reg[tdu_pkg::CTRL_TS_BIT];

  // ********************************************************************
  // APB access decode
  // ********************************************************************
  logic wr_go;
  logic wr_ok;
  logic rd_hit;
  logic [31:0] rd_data;
  logic [31:0] wd;
  logic [7:0] wa;

  assign wd = apb_req.pwdata;
  assign wa = apb_req.paddr;
  // Writes land only at the access edge that carries pready
  assign wr_go = apb_req.psel & apb_req.penable & apb_req.pwrite
    & apb_rsp.pready;
  // Writes are dropped silently while backup writes are locked
  assign wr_ok = wr_go & backup_write_unlock;

  // Read mux; unmapped offsets answer with an error
  always_comb
  begin
    rd_hit = 1'b1;
    rd_data = 32'h0;
    case (wa)
      tdu_pkg::OFS_CTRL: rd_data = ctrl_reg;
      tdu_pkg::OFS_FILT: rd_data = filt_reg;
      tdu_pkg::OFS_IRQEN: rd_data = irqen_reg;
      tdu_pkg::OFS_STAT:
      begin
        rd_data[tdu_pkg::STAT_FLAG_LSB +: NIN] = flag_reg;
        rd_data[tdu_pkg::STAT_TSF_BIT] = tsf_reg;
        rd_data[tdu_pkg::STAT_TIMESTAMP_OVERFLOW_FLAG_BIT] = timestamp_overflow_flag_reg;
      end
      tdu_pkg::OFS_CLR: rd_data = 32'h0;
      tdu_pkg::OFS_ROUTE: rd_data = route_reg;
      tdu_pkg::OFS_ASSET: rd_data = asset_reg;
      default: rd_hit = 1'b0;
    endcase
  end

  // Zero-wait slave: answer in the first access cycle
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      apb_rsp <= '0;
    else
    begin
      apb_rsp.pready <= apb_req.psel & ~apb_req.penable;
      apb_rsp.pslverr <= apb_req.psel & ~apb_req.penable & ~rd_hit;
      apb_rsp.prdata <= (apb_req.psel & ~apb_req.penable & ~apb_req.pwrite)
        ? rd_data : 32'h0;
    end
  end

  // Configuration registers
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_reg <= tdu_pkg::CTRL_RST;
      filt_reg <= tdu_pkg::FILT_RST;
      irqen_reg <= 32'h0;
      route_reg <= 32'h0;
      asset_reg <= 32'h0;
    end
    else if (wr_ok)
    begin
      case (wa)
        tdu_pkg::OFS_CTRL: ctrl_reg <= wd & tdu_pkg::CTRL_WMASK;
        tdu_pkg::OFS_FILT: filt_reg <= wd & tdu_pkg::FILT_WMASK;
        tdu_pkg::OFS_IRQEN: irqen_reg <= wd & tdu_pkg::IRQEN_WMASK;
        tdu_pkg::OFS_ROUTE: route_reg <= wd;
        tdu_pkg::OFS_ASSET: asset_reg <= wd & tdu_pkg::ASSET_WMASK;
        default: ;
      endcase
    end
  end

  // ********************************************************************
  // Pin synchroniser and edge history
  // ********************************************************************
  logic [NIN-1:0] pin_s1_reg;
  logic [NIN-1:0] pin_s2_reg;
  logic [NIN-1:0] pin_prev_reg;

  // Only the second stage and later are looked at
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      pin_prev_reg <= '0;
    end
    else
    begin
      pin_s1_reg <= tamper_input_pin;
      pin_s2_reg <= pin_s1_reg;
      pin_prev_reg <= pin_s2_reg;
    end
  end

  // ********************************************************************
  // Sample rate and precharge sequencer
  // ********************************************************************
  tdu_pkg::tdu_smp_state_t smp_state_reg;
  tdu_pkg::tdu_smp_state_t smp_state_next;
  logic [31:0] smp_cnt_reg;
  logic [31:0] smp_period;
  logic smp_tick;
  logic [3:0] prch_len;
  logic [3:0] prch_cnt_reg;

  assign smp_period = 32'(SAMPLE_BASE_CYC) >> freq_sel;
  assign smp_tick = ~edge_mode & (smp_cnt_reg >= smp_period - 32'h1);
  assign prch_len = 4'h1 << prch_sel;

  // Divider is parked in edge mode so nothing is sampled there
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      smp_cnt_reg <= 32'h0;
    else if (edge_mode || smp_tick)
      smp_cnt_reg <= 32'h0;
    else
      smp_cnt_reg <= smp_cnt_reg + 32'h1;
  end

  // Precharge for prch_len cycles, one settle cycle, then sample
  always_comb
  begin
    smp_state_next = smp_state_reg;
    case (smp_state_reg)
      tdu_pkg::SMP_IDLE:
        if (smp_tick)
          smp_state_next = tdu_pkg::SMP_PRECH;
      tdu_pkg::SMP_PRECH:
        if (prch_cnt_reg == prch_len - 4'h1)
          smp_state_next = tdu_pkg::SMP_HOLD;
      tdu_pkg::SMP_HOLD: smp_state_next = tdu_pkg::SMP_SAMPLE;
      tdu_pkg::SMP_SAMPLE: smp_state_next = tdu_pkg::SMP_IDLE;
      default: smp_state_next = tdu_pkg::SMP_IDLE;
    endcase
    if (edge_mode)
      smp_state_next = tdu_pkg::SMP_IDLE;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      smp_state_reg <= tdu_pkg::SMP_IDLE;
      prch_cnt_reg <= 4'h0;
    end
    else
    begin
      smp_state_reg <= smp_state_next;
      prch_cnt_reg <= (smp_state_next == tdu_pkg::SMP_PRECH
        && smp_state_reg == tdu_pkg::SMP_PRECH)
        ? prch_cnt_reg + 4'h1 : 4'h0;
    end
  end

  // ********************************************************************
  // Pad control
  // ********************************************************************
  logic [NIN-1:0] passive_en;
  logic prech_win;

  assign passive_en = in_en & ~act_sel;
  assign prech_win = (smp_state_next == tdu_pkg::SMP_PRECH);

  // Pull-up only as a level-mode pulse; receiver on in edge mode, in active mode and in each precharge window
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pullup_en <= '0;
      schmitt_en <= '0;
    end
    else
    begin
      pullup_en <= (~edge_mode & ~pudis & prech_win)
        ? passive_en : '0;
      schmitt_en <= (edge_mode ? passive_en : '0)
        | (prech_win ? passive_en : '0) | (in_en & act_sel);
    end
  end

  // ********************************************************************
  // Active message generator
  // ********************************************************************
  logic [15:0] act_cnt_reg;
  logic act_tick;
  logic [tdu_pkg::LFSR_W-1:0] lfsr_reg;

  assign act_tick = (act_cnt_reg == 16'(ACT_PERIOD_CYC - 1));

  // New message bit per output once each period
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      act_cnt_reg <= 16'h0;
      lfsr_reg <= tdu_pkg::LFSR_SEED;
      tamper_output_pin <= '0;
    end
    else
    begin
      act_cnt_reg <= act_tick ? 16'h0 : act_cnt_reg + 16'h1;
      if (act_tick)
      begin
        lfsr_reg <= lfsr_reg[0] ? ((lfsr_reg >> 1) ^ tdu_pkg::LFSR_TAPS)
          : (lfsr_reg >> 1);
        tamper_output_pin <= lfsr_reg[NOUT-1:0];
      end
    end
  end

  // ********************************************************************
  // Per-input detection
  // ********************************************************************
  logic [NIN-1:0] det;
  logic [NIN-1:0] act_mm;

  for (genvar i = 0; i < NIN; i++)
  begin : g_in
    logic [tdu_pkg::LVL_CNT_W-1:0] lvl_cnt_reg;
    logic [tdu_pkg::LVL_CNT_W-1:0] lvl_thr;
    logic [tdu_pkg::ACT_HIST_W-1:0] hist_reg;
    logic [tdu_pkg::ACT_HIST_W-1:0] hist_new;
    logic armed_reg;
    logic [SELW-1:0] osel;
    logic lvl_hit;
    logic edge_hit;
    logic lvl_det;
    logic act_det;
    logic [2:0] mm_sum;

    assign lvl_thr = tdu_pkg::LVL_CNT_W'(1) << flt_cnt;
    assign lvl_hit = trg_sel[i] ? ~pin_s2_reg[i] : pin_s2_reg[i];
    // Default edge is rising; the select picks falling
    assign edge_hit = trg_sel[i]
      ? (pin_prev_reg[i] & ~pin_s2_reg[i])
      : (~pin_prev_reg[i] & pin_s2_reg[i]);
    assign lvl_det = (smp_state_reg == tdu_pkg::SMP_SAMPLE) & lvl_hit
      & (lvl_cnt_reg + 1'b1 == lvl_thr);
    // Same-index output unless sharing picks another
    assign osel = ctrl_reg[tdu_pkg::CTRL_SHARE_BIT]
      ? route_reg[i*tdu_pkg::ROUTE_FW +: SELW]
      : SELW'(i % NOUT);
    assign act_mm[i] = armed_reg & act_tick
      & (pin_s2_reg[i] != tamper_output_pin[osel]);
    assign hist_new = {hist_reg[tdu_pkg::ACT_HIST_W-2:0], act_mm[i]};
    assign mm_sum = 3'(hist_new[0]) + 3'(hist_new[1])
      + 3'(hist_new[2]) + 3'(hist_new[3]);
    assign act_det = ctrl_reg[tdu_pkg::CTRL_AFLT_BIT]
      ? (act_tick & (mm_sum >= 3'(tdu_pkg::ACT_FLT_MIN)))
      : act_mm[i];
    assign det[i] = in_en[i] & (act_sel[i] ? act_det
      : (edge_mode ? edge_hit : lvl_det));

    // Consecutive-level counter restarts after each detection
    always_ff @(posedge mclk or negedge rst_n)
    begin
      if (!rst_n)
        lvl_cnt_reg <= '0;
      else if (edge_mode || !passive_en[i] || lvl_det)
        lvl_cnt_reg <= '0;
      else if (smp_state_reg == tdu_pkg::SMP_SAMPLE)
        lvl_cnt_reg <= lvl_hit ? lvl_cnt_reg + 1'b1 : '0;
    end

    // First period after enabling only arms the comparison
    always_ff @(posedge mclk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        armed_reg <= 1'b0;
        hist_reg <= '0;
      end
      else if (!(in_en[i] && act_sel[i]))
      begin
        armed_reg <= 1'b0;
        hist_reg <= '0;
      end
      else if (act_tick)
      begin
        armed_reg <= 1'b1;
        hist_reg <= hist_new;
      end
    end
  end

  // ********************************************************************
  // Flags and actions
  // ********************************************************************
  logic [NIN-1:0] flag_clr;
  logic ts_ev;
  logic stat_wr;

  assign stat_wr = wr_ok & (wa == tdu_pkg::OFS_STAT);
  // Either write-zero on the flag or write-one to the clear register
  assign flag_clr = FLAG_CLR_BY_REG
    ? ((wr_ok && wa == tdu_pkg::OFS_CLR) ? wd[NIN-1:0] : '0)
    : (stat_wr ? ~wd[tdu_pkg::STAT_FLAG_LSB +: NIN] : '0);
  // Set beats clear in the same cycle
  assign flag_next = (flag_reg & ~flag_clr) | det;
  assign ts_ev = ts_en & (|det);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      flag_reg <= '0;
    else
      flag_reg <= flag_next;
  end

  // Timestamp flags behave as for any timestamp source
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tsf_reg <= 1'b0;
      timestamp_overflow_flag_reg <= 1'b0;
      ts_capture <= 1'b0;
    end
    else
    begin
      tsf_reg <= (tsf_reg & ~(stat_wr & ~wd[tdu_pkg::STAT_TSF_BIT]))
        | ts_ev;
      timestamp_overflow_flag_reg <= (timestamp_overflow_flag_reg & ~(stat_wr & ~wd[tdu_pkg::STAT_TIMESTAMP_OVERFLOW_FLAG_BIT]))
        | (ts_ev & tsf_reg);
      ts_capture <= ts_ev;
    end
  end

  // Level interrupt and asset gate follow the sticky flags
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq <= 1'b0;
      asset_block <= 1'b0;
    end
    else
    begin
      irq <= |(flag_next & (per_ie
        | {NIN{irqen_reg[tdu_pkg::IRQ_GLB_BIT]}}));
      asset_block <= asset_reg[tdu_pkg::ASSET_EN_BIT]
        & ((|flag_next) | ctrl_reg[tdu_pkg::CTRL_BLK_BIT]);
    end
  end

  // ********************************************************************
  // Assertions
  // ********************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  logic [3:0] pu_run_reg;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      pu_run_reg <= 4'h0;
    else
      pu_run_reg <= pullup_en[0] ? pu_run_reg + 4'h1 : 4'h0;
  end

  edge_rise_flag_a: assert property (
    edge_mode && passive_en[0] && !trg_sel[0]
    && !pin_prev_reg[0] && pin_s2_reg[0] |=> flag_reg[0])
    else $error("rising edge did not set flag");
  edge_no_prech_a: assert property (
    edge_mode && $past(edge_mode) |-> pullup_en == '0
    && smp_cnt_reg == 32'h0)
    else $error("precharge or sampling in edge mode");
  pudis_no_pull_a: assert property (
    pudis && $past(pudis) |-> pullup_en == '0)
    else $error("pull-up applied while disabled");
  prech_len_a: assert property (
    $fell(pullup_en[0]) && $stable(prch_sel) |-> pu_run_reg == prch_len)
    else $error("precharge pulse length wrong");
  schmitt_off_a: assert property (
    !edge_mode && !pudis && !act_sel[0] && $stable(filt_reg)
    && $stable(ctrl_reg) && !pullup_en[0] |-> !schmitt_en[0])
    else $error("receiver on without pull-up");
  disabled_quiet_a: assert property (
    !in_en[0] |-> !det[0])
    else $error("disabled input detected");
  irq_follow_a: assert property (
    (flag_reg[0] && per_ie[0] && $stable(per_ie[0])) |-> irq)
    else $error("interrupt missing");
  flag_sticky_a: assert property (
    flag_reg[0] && !flag_clr[0] |=> flag_reg[0])
    else $error("flag dropped without clear");
  ts_trigger_a: assert property (
    ts_en && |det |=> tsf_reg && ts_capture ##1 tsf_reg)
    else $error("timestamp not triggered");
  asset_gate_a: assert property (
    asset_reg[0] && ctrl_reg[tdu_pkg::CTRL_BLK_BIT] |=> asset_block)
    else $error("asset not blocked");
  act_filter_a: assert property (
    ctrl_reg[tdu_pkg::CTRL_AFLT_BIT] && act_sel[0]
    && g_in[0].hist_reg == '0 |-> !det[0])
    else $error("single mismatch passed the filter");

endmodule // tdu_top

// *** sim/tdu_switch_model.sv ***
/*
  Model of the switches and loop-back mesh wired to the tamper pins.
  Assumes an external pull-up on each switch and the bench steering it.
*/
`timescale 1ns/1ps
module tdu_switch_model (
  // Pins driven by the unit
  input wire logic [3:0] tamper_output_pin,
  // Bench control: switch closed to ground, mesh fitted, mesh cut
  input wire logic [3:0] closed,
  input wire logic [3:0] mesh,
  input wire logic [3:0] cut,
  // Pins read by the unit
  output logic [3:0] pin
);
  // Mesh returns the same-index output; a cut wire inverts it
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      pin[i] = mesh[i] ? tamper_output_pin[i] ^ cut[i] : !closed[i];
  end
endmodule // tdu_switch_model

// *** sim/testbench.sv ***
/*
  Self-checking bench: APB register calls and pin stimulus.
  Assumes tdu_switch_model on the pins and a short sample base.
*/
`timescale 1ns/1ps
module testbench;
  logic mclk, rst_n, unlock, irq, tsc, blk, err;
  tdu_pkg::tdu_apb_req_t req;
  tdu_pkg::tdu_apb_rsp_t rsp;
  logic [3:0] pin, outp, pu, st, closed, mesh, cut;
  logic [31:0] rd;
  int err_count, total_checks, n;
  // ********
  // Clock and parts
  // ********
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  tdu_top #(.SAMPLE_BASE_CYC(2048), .ACT_PERIOD_CYC(4)) dut_u (
    .mclk(mclk), .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp),
    .backup_write_unlock(unlock), .tamper_input_pin(pin),
    .tamper_output_pin(outp), .pullup_en(pu), .schmitt_en(st),
    .irq(irq), .ts_capture(tsc), .asset_block(blk));
  tdu_switch_model sw_u (.tamper_output_pin(outp), .closed(closed),
    .mesh(mesh), .cut(cut), .pin(pin));
  // ********
  // Tasks
  // ********
  // Holds the request until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int k;
    @(posedge mclk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge mclk);
    req.penable <= 1'b1;
    k = 0;
    @(posedge mclk);
    while (rsp.pready !== 1'b1 && k < 20)
    begin
      @(posedge mclk);
      k++;
    end
    if (k == 20)
      err_count++;
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  // Flags by the clear register, timestamp bits by writing zero
  task automatic clear;
    wr(tdu_pkg::OFS_CLR, 32'hff);
    wr(tdu_pkg::OFS_STAT, 32'h0);
  endtask
  task automatic wait_pu(input logic lvl);
    n = 0;
    while (pu[0] !== lvl && n < 100)
    begin
      @(posedge mclk);
      n++;
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog: the run needs a few thousand cycles at most
  initial
  begin
    #200000;
    err_count++;
    report_and_stop;
  end
  // ********
  // Tests
  // ********
  initial
  begin
    rst_n = 1'b0;
    unlock = 1'b1;
    req = '0;
    closed = 4'hf;
    mesh = 4'h0;
    cut = 4'h0;
    err_count = 0;
    total_checks = 0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    rchk(tdu_pkg::OFS_CTRL, 32'h0);
    rchk(tdu_pkg::OFS_FILT, 32'h0);
    xfer(1'b0, 8'h1c, 32'h0);
    chk(err, 1'b1);
    $display("test reset done");
    // Rising edges on inputs 0 and 1, only input 0 enabled
    wr(tdu_pkg::OFS_CTRL, 32'h1);
    wr(tdu_pkg::OFS_IRQEN, 32'h100);
    wr(tdu_pkg::OFS_ASSET, 32'h1);
    closed <= 4'hc;
    repeat (8) @(posedge mclk);
    rchk(tdu_pkg::OFS_STAT, 32'h1);
    chk(irq, 1'b1);
    chk(blk, 1'b1);
    chk(pu, 4'h0);
    clear;
    rchk(tdu_pkg::OFS_STAT, 32'h0);
    $display("test edge done");
    // Falling trigger on input 2: a rise is ignored, a fall stamps time
    wr(tdu_pkg::OFS_CTRL, 32'h0100_0404);
    closed <= 4'h8;
    repeat (8) @(posedge mclk);
    rchk(tdu_pkg::OFS_STAT, 32'h0);
    closed <= 4'hc;
    repeat (8) @(posedge mclk);
    rchk(tdu_pkg::OFS_STAT, 32'h104);
    clear;
    $display("test timestamp done");
    // Level high, two samples, fastest rate, four-cycle precharge
    wr(tdu_pkg::OFS_CTRL, 32'h1);
    wr(tdu_pkg::OFS_IRQEN, 32'h1);
    wr(tdu_pkg::OFS_FILT, 32'h4f);
    wait_pu(1'b1);
    wait_pu(1'b0);
    chk(n, 4);
    chk(st, 4'h0);
    repeat (60) @(posedge mclk);
    rchk(tdu_pkg::OFS_STAT, 32'h1);
    chk(irq, 1'b1);
    // Disable the pull-up between pulses so no pulse is cut short
    wait_pu(1'b1);
    wait_pu(1'b0);
    wr(tdu_pkg::OFS_FILT, 32'hcf);
    wait_pu(1'b1);
    chk(n, 100);
    $display("test level done");
    // Active mesh on input 3: intact, then cut
    wr(tdu_pkg::OFS_FILT, 32'h0);
    mesh <= 4'h8;
    wr(tdu_pkg::OFS_CTRL, 32'h0008_0008);
    repeat (20) @(posedge mclk);
    clear;
    repeat (20) @(posedge mclk);
    rchk(tdu_pkg::OFS_STAT, 32'h0);
    cut <= 4'h8;
    repeat (20) @(posedge mclk);
    rchk(tdu_pkg::OFS_STAT, 32'h8);
    $display("test active done");
    // Inputs 0 and 3 shared onto their own outputs, filter on; 0 cut
    cut <= 4'h0;
    mesh <= 4'h9;
    wr(tdu_pkg::OFS_ROUTE, 32'h3000);
    wr(tdu_pkg::OFS_CTRL, 32'h0c09_0009);
    repeat (20) @(posedge mclk);
    clear;
    repeat (20) @(posedge mclk);
    rchk(tdu_pkg::OFS_STAT, 32'h0);
    cut <= 4'h1;
    repeat (20) @(posedge mclk);
    rchk(tdu_pkg::OFS_STAT, 32'h1);
    $display("test filter done");
    // Block bit alone keeps the asset closed once flags are clear
    wr(tdu_pkg::OFS_CTRL, 32'h0200_0000);
    clear;
    @(posedge mclk);
    chk(blk, 1'b1);
    $display("test block done");
    report_and_stop;
  end
endmodule // testbench
